//--- rtl/rml_regen_maint.sv
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
`default_nettype none
module rml_regen_maint
  import rml_pkg::*;
#(
  parameter int NPAIR    = rml_pkg::NPAIR_DEF,
  parameter int LOSS_CYC = rml_pkg::LOSS_HOLD_CYC
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     srst,
  // register bus
  input  wire logic [rml_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  output logic [31:0]                   avs_readdata,
  output logic                          avs_waitrequest,
  // line status of both transceiver sides
  input  wire logic                     los_r,
  input  wire logic                     lfa_r,
  input  wire logic                     los_c,
  input  wire logic                     lfa_c,
  input  wire logic                     busy_r,
  input  wire logic                     busy_c,
  input  wire logic                     entered_off_r,
  input  wire logic                     entered_off_c,
  input  wire logic                     link_r_up,
  // transceiver control
  output logic                          deact_r,
  output logic                          deact_c,
  output logic                          start_c,
  output logic                          reset_c,
  output logic                          loop_active,
  // operations channel
  input  wire logic                     eoc_valid,
  input  wire logic [1:0]               eoc_addr,
  input  wire logic [7:0]               eoc_code,
  input  wire logic [7:0]               eoc_data,
  output logic                          eoc_tx_valid,
  output logic [1:0]                    eoc_tx_addr,
  output logic [7:0]                    eoc_tx_code,
  output logic [7:0]                    eoc_tx_data,
  output logic                          eoc_fwd,
  // overhead indicator bits
  input  wire logic [rml_pkg::OH_W-1:0] oh_rx_r,
  input  wire logic [rml_pkg::OH_W-1:0] oh_rx_c,
  output logic [rml_pkg::OH_W-1:0]      oh_tx_r,
  output logic [rml_pkg::OH_W-1:0]      oh_tx_c,
  // local error and alarm sources
  input  wire logic                     crc_err_r,
  input  wire logic                     crc_err_c,
  input  wire logic                     clk_lost,
  input  wire logic                     delay_exceeded,
  input  wire logic                     mem_fail,
  input  wire logic [NPAIR-1:0]         frame_tick,
  input  wire logic [NPAIR-1:0]         frame_err,
  output logic [NPAIR-1:0]              eer
);
  import rml_pkg::*;

  typedef struct packed {
    rml_loop_t       loop;
    logic            waitreq;
    logic [31:0]     rdata;
    logic [1:0]      ctrl;
    logic [7:0]      equip;
    logic [7:0]      cfg;
    logic            deact_r;
    logic            deact_c;
    logic            start_c;
    logic            reset_c;
    logic            tx_valid;
    logic [1:0]      tx_addr;
    logic [7:0]      tx_code;
    logic [7:0]      tx_data;
    logic            fwd;
    logic [OH_W-1:0] oh_r;
    logic [OH_W-1:0] oh_c;
    logic            exp_r_d;
    logic            exp_c_d;
    logic [NPAIR-1:0] eer;
  } rml_st_t;

  rml_st_t          st;
  rml_st_t          next_st;
  logic             exp_r;
  logic             exp_c;
  logic [NPAIR-1:0] eer_w;
  logic             alarm;
  logic             loss_off;
  logic             own_msg;

  // status word: live state over the software-held equipment bits
  function automatic logic [31:0] status_word(input rml_st_t s,
                                              input logic    alm);
    logic [31:0] w;
    w      = {24'h000000, s.equip};
    w[0]   = w[0] | (s.loop == RML_LOOPED);
    w[1]   = w[1] | alm;
    w[2]   = w[2] | (|s.eer);
    return w;
  endfunction

  // replace the regenerator's own bits in an outgoing overhead word
  function automatic logic [OH_W-1:0] own_bits(input logic [OH_W-1:0] b,
                                               input logic alm,
                                               input logic er,
                                               input logic ec);
    logic [OH_W-1:0] o;
    o          = b;
    o[OH_HRP]  = 1'b0;
    o[OH_REGA] = alm;
    o[OH_RRBE] = er;
    o[OH_RCBE] = ec;
    return o;
  endfunction

  rml_persist #(.CYCLES(LOSS_CYC)) u_hold_r (
    .clk     (clk),
    .srst    (srst),
    .cond    (los_r | lfa_r),
    .expired (exp_r)
  );

  rml_persist #(.CYCLES(LOSS_CYC)) u_hold_c (
    .clk     (clk),
    .srst    (srst),
    .cond    (los_c | lfa_c),
    .expired (exp_c)
  );

  genvar gp;
  generate
    for (gp = 0; gp < NPAIR; gp++) begin : g_pair
      rml_errmon #(.WINDOW(ERR_WINDOW), .LIMIT(ERR_LIMIT)) u_em (
        .clk        (clk),
        .srst       (srst),
        .frame_tick (frame_tick[gp]),
        .frame_err  (frame_err[gp]),
        .eer        (eer_w[gp])
      );
    end
  endgenerate

  assign alarm = clk_lost | delay_exceeded | mem_fail
               | st.ctrl[CTRL_ALARM];
  assign loss_off = (exp_r & ~st.exp_r_d) | (exp_c & ~st.exp_c_d);
  assign own_msg  = eoc_valid & (eoc_addr == REG_ADDR);

  always_comb begin
    next_st          = st;
    next_st.exp_r_d  = exp_r;
    next_st.exp_c_d  = exp_c;
    next_st.eer      = eer_w;
    next_st.deact_r  = 1'b0;
    next_st.deact_c  = 1'b0;
    next_st.start_c  = 1'b0;
    next_st.reset_c  = 1'b0;
    next_st.tx_valid = 1'b0;
    next_st.fwd      = 1'b0;

    // bus slave: one wait cycle, transfer at the edge waitrequest is low
    if (!st.waitreq) begin
      next_st.waitreq = 1'b1;
      if (avs_write) begin
        case (avs_address)
          REG_CTRL:  next_st.ctrl  = avs_writedata[1:0];
          REG_EQUIP: next_st.equip = avs_writedata[7:0];
          REG_CFG:   next_st.cfg   = avs_writedata[7:0];
          default:   next_st.ctrl  = st.ctrl;
        endcase
      end
    end else if (avs_read || avs_write) begin
      next_st.waitreq = 1'b0;
      case (avs_address)
        REG_CTRL:   next_st.rdata = {30'h0, st.ctrl};
        REG_STATUS: next_st.rdata = status_word(st, alarm);
        REG_EQUIP:  next_st.rdata = {24'h000000, st.equip};
        REG_CFG:    next_st.rdata = {24'h000000, st.cfg};
        default:    next_st.rdata = 32'h00000000;
      endcase
    end

    // loss on either side takes both sides down
    if (loss_off) begin
      next_st.deact_r = 1'b1;
      next_st.deact_c = 1'b1;
    end
    // one side down forces the other if it is up
    if (entered_off_r && busy_c)
      next_st.deact_c = 1'b1;
    if (entered_off_c && busy_r)
      next_st.deact_r = 1'b1;

    // operations channel
    if (own_msg) begin
      // own address handled while looped too
      case (eoc_code)
        EOC_LOOP1A: begin
          next_st.loop    = RML_LOOPED;
          // optional retrain of network side on live link
          next_st.reset_c = busy_c & st.ctrl[CTRL_LRST];
        end
        EOC_RTN: begin
          if (st.loop == RML_LOOPED) begin
            // drop network side and cancel loop
            next_st.loop    = RML_NORMAL;
            next_st.deact_c = 1'b1;
            next_st.start_c = link_r_up;
          end
        end
        EOC_STAT_REQ: begin
          next_st.tx_valid = 1'b1;
          next_st.tx_addr  = REG_ADDR;
          next_st.tx_code  = EOC_STAT_REPLY;
          next_st.tx_data  = 8'(status_word(st, alarm));
        end
        EOC_CFG_RD: begin
          next_st.tx_valid = 1'b1;
          next_st.tx_addr  = REG_ADDR;
          next_st.tx_code  = EOC_CFG_REPLY;
          next_st.tx_data  = st.cfg;
        end
        EOC_CFG_WR: begin
          // remote write wins over a bus write
          next_st.cfg      = eoc_data;
          next_st.tx_valid = 1'b1;
          next_st.tx_addr  = REG_ADDR;
          next_st.tx_code  = EOC_CFG_REPLY;
          next_st.tx_data  = eoc_data;
        end
        default: next_st.tx_valid = 1'b0;
      endcase
    end else if (eoc_valid) begin
      if (st.loop == RML_LOOPED) begin
        next_st.tx_valid = 1'b1;
        next_st.tx_addr  = REG_ADDR;
        next_st.tx_code  = EOC_HOLD;
        next_st.tx_data  = 8'h00;
      end else begin
        next_st.fwd = 1'b1;
      end
    end

    // line deactivation also releases the loop
    if (loss_off || entered_off_r || entered_off_c)
      next_st.loop = RML_NORMAL;

    // looped bits return to terminal, own bits stay live
    // rrbe, rcbe local; febe passes from terminal side when looped, else from network side
    // ps1/ps2 and losd ride through unchanged
    if (st.loop == RML_LOOPED)
      next_st.oh_r = own_bits(oh_rx_r, alarm, crc_err_r, crc_err_c);
    else
      next_st.oh_r = own_bits(oh_rx_c, alarm, crc_err_r, crc_err_c);
    // transparent loop: terminal side always forwarded
    next_st.oh_c = oh_rx_r;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st         <= '0;
      st.loop    <= RML_NORMAL;
      st.waitreq <= 1'b1;
      st.ctrl    <= CTRL_RST;
      st.cfg     <= CFG_RST;
      st.equip   <= EQUIP_RST;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata    = st.rdata;
  assign avs_waitrequest = st.waitreq;
  assign deact_r         = st.deact_r;
  assign deact_c         = st.deact_c;
  assign start_c         = st.start_c;
  assign reset_c         = st.reset_c;
  assign loop_active     = (st.loop == RML_LOOPED);
  assign eoc_tx_valid    = st.tx_valid;
  assign eoc_tx_addr     = st.tx_addr;
  assign eoc_tx_code     = st.tx_code;
  assign eoc_tx_data     = st.tx_data;
  assign eoc_fwd         = st.fwd;
  assign oh_tx_r         = st.oh_r;
  assign oh_tx_c         = st.oh_c;
  assign eer             = st.eer;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence loop_req_s;
    own_msg && eoc_code == EOC_LOOP1A;
  endsequence
  sequence rtn_req_s;
    loop_active && own_msg && eoc_code == EOC_RTN;
  endsequence
  sequence foreign_s;
    loop_active && eoc_valid && eoc_addr != REG_ADDR;
  endsequence

  loss_both_a: assert property ($rose(exp_c) |=> deact_r && deact_c)
    else $error("loss did not take both sides down");
  loop_close_a: assert property (loop_req_s and (!loss_off
      && !entered_off_r && !entered_off_c) |=> loop_active)
    else $error("loop not closed on request");
  loop_fwd_a: assert property (loop_active |=>
      oh_tx_c == $past(oh_rx_r))
    else $error("looped signal not forwarded");
  hold_reply_a: assert property (foreign_s |=> eoc_tx_valid
      && eoc_tx_code == EOC_HOLD && eoc_tx_addr == REG_ADDR)
    else $error("no hold state reply");
  looped_bits_a: assert property (loop_active |=>
      oh_tx_r[OH_FEBE] == $past(oh_rx_r[OH_FEBE])
      && oh_tx_r[OH_RRBE] == $past(crc_err_r))
    else $error("indicator bits not looped");
  rtn_end_a: assert property (rtn_req_s |=> deact_c && !loop_active)
    else $error("return to normal not applied");
  restart_a: assert property (rtn_req_s and link_r_up |=> start_c)
    else $error("network side not restarted");
  force_off_a: assert property (entered_off_c && busy_r |=> deact_r)
    else $error("other side not forced down");
  status_reply_a: assert property (own_msg && eoc_code == EOC_STAT_REQ
      |=> eoc_tx_valid && eoc_tx_code == EOC_STAT_REPLY)
    else $error("status request not answered");
  latch_a: assert property (loop_active && !eoc_valid && !loss_off
      && !entered_off_r && !entered_off_c |=> loop_active)
    else $error("loop dropped without cause");
endmodule // rml_regen_maint
`default_nettype wire

//--- rtl/rml_pkg.sv
`default_nettype none
package rml_pkg;
  // timing at the 10 MHz core clock
  localparam int CLK_HZ        = 10_000_000;
  localparam int LOSS_HOLD_MS  = 2000;
  localparam int LOSS_HOLD_CYC = (CLK_HZ / 1000) * LOSS_HOLD_MS;
  // excessive error ratio: errored frames out of a one-second window
  localparam int ERR_WINDOW    = 166;
  localparam int ERR_LIMIT     = 150;
  localparam int NPAIR_DEF     = 3;

  // operations channel
  localparam logic [1:0] REG_ADDR       = 2'h2;
  localparam logic [7:0] EOC_LOOP1A     = 8'h50;
  localparam logic [7:0] EOC_RTN        = 8'hFF;
  localparam logic [7:0] EOC_HOLD       = 8'h3F;
  localparam logic [7:0] EOC_STAT_REQ   = 8'h20;
  localparam logic [7:0] EOC_CFG_RD     = 8'h21;
  localparam logic [7:0] EOC_CFG_WR     = 8'h22;
  localparam logic [7:0] EOC_STAT_REPLY = 8'h30;
  localparam logic [7:0] EOC_CFG_REPLY  = 8'h31;

  // overhead indicator bit positions
  localparam int OH_W    = 9;
  localparam int OH_HRP  = 0;
  localparam int OH_REGA = 1;
  localparam int OH_RRBE = 2;
  localparam int OH_RCBE = 3;
  localparam int OH_FEBE = 4;
  localparam int OH_RTA  = 5;
  localparam int OH_PS1  = 6;
  localparam int OH_PS2  = 7;
  localparam int OH_LOSD = 8;

  // register map, byte addresses
  localparam int ADDR_W = 5;
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_EQUIP  = 5'h08;
  localparam logic [4:0] REG_CFG    = 5'h0C;
  localparam int CTRL_LRST  = 0;
  localparam int CTRL_ALARM = 1;
  localparam logic [1:0] CTRL_RST  = 2'h1;
  localparam logic [7:0] CFG_RST   = 8'h00;
  localparam logic [7:0] EQUIP_RST = 8'h00;

  typedef enum logic {RML_NORMAL, RML_LOOPED} rml_loop_t;
endpackage
`default_nettype wire

//--- rtl/rml_persist.sv
`timescale 1ns/1ns
`default_nettype none
module rml_persist #(
  parameter int CYCLES = 2
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // condition and result
  input  wire logic cond,
  output logic      expired
);
  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          expired;
  } rml_pst_t;

  rml_pst_t st;
  rml_pst_t next_st;

  always_comb begin
    next_st = st;
    if (!cond) begin
      next_st.cnt     = '0;
      next_st.expired = 1'b0;
    end else if (st.cnt == CW'(CYCLES - 1)) begin
      next_st.expired = 1'b1;
    end else begin
      next_st.cnt = st.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) st <= '0;
    else st <= next_st;
  end

  assign expired = st.expired;

  // loss held for the full time
  hold_full_a: assert property (@(posedge clk) disable iff (srst)
    $rose(expired) |-> $past(cond) && $past(st.cnt) == CW'(CYCLES - 1))
    else $error("persistence expired early");
endmodule // rml_persist
`default_nettype wire

//--- rtl/rml_errmon.sv
`timescale 1ns/1ns
`default_nettype none
module rml_errmon #(
  parameter int WINDOW = 166,
  parameter int LIMIT  = 150
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // per-frame report from the pair
  input  wire logic frame_tick,
  input  wire logic frame_err,
  output logic      eer
);
  localparam int CW = $clog2(WINDOW + 1);

  typedef struct packed {
    logic [CW-1:0] frm;
    logic [CW-1:0] errs;
    logic          eer;
  } rml_em_t;

  rml_em_t       st;
  rml_em_t       next_st;
  logic [CW-1:0] sum;

  always_comb begin
    next_st = st;
    sum     = st.errs + CW'(frame_err);
    if (frame_tick) begin
      if (st.frm == CW'(WINDOW - 1)) begin
        next_st.eer  = (sum >= CW'(LIMIT));
        next_st.frm  = '0;
        next_st.errs = '0;
      end else begin
        next_st.frm  = st.frm + CW'(1);
        next_st.errs = sum;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) st <= '0;
    else st <= next_st;
  end

  assign eer = st.eer;
endmodule // rml_errmon
`default_nettype wire

//--- test/rml_lt_model.sv
`timescale 1ns/1ns
`default_nettype none
module rml_lt_model (
  // clock
  input  wire logic       clk,
  // messages toward the regenerator
  output logic            eoc_valid,
  output logic [1:0]      eoc_addr,
  output logic [7:0]      eoc_code,
  output logic [7:0]      eoc_data,
  // replies from the regenerator
  input  wire logic       eoc_tx_valid,
  input  wire logic [1:0] eoc_tx_addr,
  input  wire logic [7:0] eoc_tx_code,
  input  wire logic [7:0] eoc_tx_data
);
  logic [17:0] replies[$];

  initial begin
    eoc_valid = 1'b0;
    eoc_addr  = 2'h0;
    eoc_code  = 8'h00;
    eoc_data  = 8'h00;
  end

  // one whole message
  // released fields are inverted so a stale message never looks valid
  task automatic send(input logic [1:0] a, input logic [7:0] c,
                      input logic [7:0] d);
    @(posedge clk);
    eoc_valid <= 1'b1;
    eoc_addr  <= a;
    eoc_code  <= c;
    eoc_data  <= d;
    @(posedge clk);
    eoc_valid <= 1'b0;
    eoc_addr  <= ~a;
    eoc_code  <= ~c;
    eoc_data  <= ~d;
  endtask

  always @(posedge clk) begin
    if (eoc_tx_valid === 1'b1) begin
      replies.push_back({eoc_tx_addr, eoc_tx_code, eoc_tx_data});
    end
  end
endmodule // rml_lt_model
`default_nettype wire

//--- test/rml_regen_maint_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module rml_regen_maint_tb_top;
  import rml_pkg::*;
  localparam int LC = 8;
  localparam int NP = 3;
  logic clk, srst, avs_read, avs_write, avs_waitrequest;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic los_r, lfa_r, los_c, lfa_c, busy_r, busy_c, link_r_up;
  logic entered_off_r, entered_off_c, loop_active;
  logic deact_r, deact_c, start_c, reset_c;
  logic eoc_valid, eoc_tx_valid, eoc_fwd;
  logic [1:0] eoc_addr, eoc_tx_addr, ctrl_m;
  logic [7:0] eoc_code, eoc_data, eoc_tx_code, eoc_tx_data, equip_m, v;
  logic [OH_W-1:0] oh_rx_r, oh_rx_c, oh_tx_r, oh_tx_c;
  logic crc_err_r, crc_err_c, clk_lost, delay_exceeded, mem_fail;
  logic [NP-1:0] frame_tick, frame_err, eer;
  int failures, n_compared, seed, n_dr, n_dc, n, loop_m;
  logic [17:0] exp_q[$];

  rml_regen_maint #(.NPAIR(NP), .LOSS_CYC(LC)) i_rml_regen_maint (
    .clk(clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .los_r(los_r), .lfa_r(lfa_r),
    .los_c(los_c), .lfa_c(lfa_c), .busy_r(busy_r), .busy_c(busy_c),
    .entered_off_r(entered_off_r), .entered_off_c(entered_off_c),
    .link_r_up(link_r_up), .deact_r(deact_r), .deact_c(deact_c),
    .start_c(start_c), .reset_c(reset_c), .loop_active(loop_active),
    .eoc_valid(eoc_valid), .eoc_addr(eoc_addr), .eoc_code(eoc_code),
    .eoc_data(eoc_data), .eoc_tx_valid(eoc_tx_valid),
    .eoc_tx_addr(eoc_tx_addr), .eoc_tx_code(eoc_tx_code),
    .eoc_tx_data(eoc_tx_data), .eoc_fwd(eoc_fwd), .oh_rx_r(oh_rx_r),
    .oh_rx_c(oh_rx_c), .oh_tx_r(oh_tx_r), .oh_tx_c(oh_tx_c),
    .crc_err_r(crc_err_r), .crc_err_c(crc_err_c), .clk_lost(clk_lost),
    .delay_exceeded(delay_exceeded), .mem_fail(mem_fail),
    .frame_tick(frame_tick), .frame_err(frame_err), .eer(eer));

  rml_lt_model i_rml_lt_model (
    .clk(clk), .eoc_valid(eoc_valid), .eoc_addr(eoc_addr),
    .eoc_code(eoc_code), .eoc_data(eoc_data),
    .eoc_tx_valid(eoc_tx_valid), .eoc_tx_addr(eoc_tx_addr),
    .eoc_tx_code(eoc_tx_code), .eoc_tx_data(eoc_tx_data));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(negedge clk) begin
    if (deact_r === 1'b1) n_dr++;
    if (deact_c === 1'b1) n_dc++;
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // the master waits on the answer; only the watchdog ends a hang
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= wd;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic msg(input logic [1:0] a, input logic [7:0] c, dd);
    i_rml_lt_model.send(a, c, dd);
    @(negedge clk);
  endtask

  function automatic logic [8:0] exp_ohr();
    logic [8:0] r;
    r = (loop_m != 0) ? oh_rx_r : oh_rx_c;
    r[OH_HRP] = 1'b0;
    r[OH_REGA] = clk_lost | delay_exceeded | mem_fail | ctrl_m[1];
    r[OH_RRBE] = crc_err_r;
    r[OH_RCBE] = crc_err_c;
    return r;
  endfunction

  task automatic oh_steps();
    repeat (6) begin
      @(posedge clk);
      oh_rx_r <= OH_W'($random(seed));
      oh_rx_c <= OH_W'($random(seed));
      {crc_err_r, crc_err_c, clk_lost, delay_exceeded, mem_fail}
        <= 5'($random(seed));
      repeat (2) @(negedge clk);
      chk("oh_tx_r", 32'(oh_tx_r), 32'(exp_ohr()));
      chk("oh_tx_c", 32'(oh_tx_c), 32'(oh_rx_r));
    end
    @(posedge clk);
    {crc_err_r, crc_err_c, clk_lost, delay_exceeded, mem_fail} <= 5'h00;
  endtask

  task automatic loop_on(input logic [2:0] want_reset);
    msg(REG_ADDR, EOC_LOOP1A, 8'h00);
    loop_m = 1;
    chk("loop_on", 32'(loop_active), 32'h1);
    chk("reset_c", 32'(reset_c), 32'(want_reset));
  endtask

  task automatic rtn(input logic up);
    msg(REG_ADDR, EOC_RTN, 8'h00);
    loop_m = 0;
    chk("loop_off", 32'(loop_active), 32'h0);
    chk("deact_c", 32'(deact_c), 32'h1);
    chk("start_c", 32'(start_c), 32'(up));
  endtask

  initial begin
    seed = 19;
    {srst, link_r_up, ctrl_m} = 4'hD;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {los_r, lfa_r, los_c, lfa_c, busy_r, busy_c} = 6'h00;
    {entered_off_r, entered_off_c, oh_rx_r, oh_rx_c} = '0;
    {crc_err_r, crc_err_c, clk_lost, delay_exceeded, mem_fail} = 5'h00;
    {frame_tick, frame_err, failures, n_compared, n_dr, n_dc, loop_m} = '0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk("wait_rst", 32'(avs_waitrequest), 32'h1);
    bus(1'b0, REG_CTRL, 0, d);
    chk("ctrl", d, 32'(CTRL_RST));
    bus(1'b0, REG_CFG, 0, d);
    chk("cfg", d, 32'(CFG_RST));
    bus(1'b1, 5'h10, $random(seed), d);
    bus(1'b0, 5'h10, 0, d);
    chk("unmapped", d, 32'h0);
    equip_m = 8'($random(seed)) & 8'hF8;
    bus(1'b1, REG_EQUIP, $random(seed) & 32'h0 | 32'(equip_m), d);
    bus(1'b1, REG_STATUS, 32'hFFFFFFFF, d);
    bus(1'b0, REG_STATUS, 0, d);
    chk("status", d, 32'(equip_m));
    $display("registers done");
    msg(2'h1, EOC_STAT_REQ, 8'h00);
    chk("fwd", 32'(eoc_fwd), 32'h1);
    rtn_ignored: begin
      n = n_dc;
      msg(REG_ADDR, EOC_RTN, 8'h00);
      chk("rtn_idle", 32'(n_dc - n), 32'h0);
    end
    @(posedge clk);
    busy_c <= 1'b1;
    loop_on(3'h1);
    exp_q.delete();
    for (int a = 0; a < 4; a++) begin
      if (a == 2) continue;
      msg(2'(a), EOC_STAT_REQ, 8'h00);
      chk("fwd_loop", 32'(eoc_fwd), 32'h0);
      exp_q.push_back({REG_ADDR, EOC_HOLD, 8'h00});
    end
    msg(REG_ADDR, EOC_STAT_REQ, 8'h00);
    exp_q.push_back({REG_ADDR, EOC_STAT_REPLY, equip_m | 8'h01});
    v = 8'($random(seed));
    msg(REG_ADDR, EOC_CFG_WR, v);
    msg(REG_ADDR, EOC_CFG_RD, 8'h00);
    repeat (2) exp_q.push_back({REG_ADDR, EOC_CFG_REPLY, v});
    oh_steps();
    rtn(1'b1);
    bus(1'b0, REG_CFG, 0, d);
    chk("cfg_remote", d, 32'(v));
    chk("n_replies", 32'(i_rml_lt_model.replies.size()), 32'h6);
    while (exp_q.size() > 0 && i_rml_lt_model.replies.size() > 0) begin
      chk("reply", 32'(i_rml_lt_model.replies.pop_front()), 32'(exp_q.pop_front()));
    end
    ctrl_m = 2'h2;
    bus(1'b1, REG_CTRL, 32'(ctrl_m), d);
    oh_steps();
    loop_on(3'h0);
    @(posedge clk);
    link_r_up <= 1'b0;
    rtn(1'b0);
    $display("loopback done");
    loop_on(3'h0);
    @(posedge clk);
    los_c <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (deact_r !== 1'b1 && n < 40);
    chk("loss_delay", 32'(n >= LC && n <= LC + 3), 32'h1);
    chk("deact_both", 32'(deact_c), 32'h1);
    @(negedge clk);
    chk("loop_lost", 32'(loop_active), 32'h0);
    @(posedge clk);
    {los_c, lfa_r} <= 2'h1;
    n = n_dr;
    repeat (LC - 2) @(posedge clk);
    lfa_r <= 1'b0;
    repeat (12) @(negedge clk);
    chk("short_loss", 32'(n_dr - n), 32'h0);
    for (int i = 0; i < 2; i++) begin
      n = n_dr;
      @(posedge clk);
      {busy_r, entered_off_c} <= {1'(i), 1'b1};
      @(posedge clk);
      entered_off_c <= 1'b0;
      repeat (4) @(negedge clk);
      chk("force_r", 32'(n_dr - n), 32'(i));
    end
    $display("deactivation done");
    for (int i = 0; i < ERR_WINDOW; i++) begin
      @(posedge clk);
      frame_tick <= '1;
      frame_err <= {1'b1, 1'(i >= ERR_WINDOW - ERR_LIMIT + 1),
                    1'(i >= ERR_WINDOW - ERR_LIMIT)};
      @(posedge clk);
      frame_tick <= '0;
      @(negedge clk);
      if (i == ERR_WINDOW - 2) chk("eer_early", 32'(eer), 32'h0);
    end
    repeat (3) @(negedge clk);
    chk("eer", 32'(eer), 32'h5);
    bus(1'b0, REG_STATUS, 0, d);
    chk("status_eer", d & 32'h4, 32'h4);
    $display("error ratio done");
    stop_test();
  end

  initial begin
    #(6000 * 100);
    failures++;
    $display("watchdog expired");
    stop_test();
  end
endmodule // rml_regen_maint_tb_top
`default_nettype wire
